// ---- include/ccs_pkg.sv ----
// Constants, register map and source codes of the clock source selection block
// Overview of operation
// - Instruction clock is the selected processor clock divided by two
// - Power-on source comes from primary mode and initial source configuration fields
// - Unprogrammed configuration starts on fast RC with postscaler, code 111, mode 11
// - Two-bit external clock range field; unprogrammed means above 8 MHz
// - Software clock switching only when upper switch-mode bit is zero
// - Fail-safe monitor active only when switch-mode field equals 00
// - Codes 111,110,101,100,001,000 select the internal and secondary sources
// - Primary codes use mode 10 high-speed, 01 standard crystal, 00 external clock
// - Only primary and 8 MHz fast RC may pass through the 4x multiplier
// - Fast RC frequency lowered by a software divider ahead of selection
// - One configuration bit picks high or low power secondary oscillator
// - Crystal output pin function follows a configuration bit, may carry instruction clock
// - Current source read-only, clock fail clear-only, selection lock set-only
// - With switching disabled, request bit stays zero and new source is ignored
// - On request compare codes; equal aborts, otherwise clear lock and fail flags
// - When new source ready wait 10 new clocks, switch, clear request, copy code
package ccs_pkg;
  // Register indices on the plain register port
  localparam logic [3:0] CCS_IDX_OSC_CTRL = 4'h0;
  localparam logic [3:0] CCS_IDX_IRQ_STATUS = 4'h1;
  localparam logic [3:0] CCS_IDX_IRQ_MASK = 4'h2;
  localparam logic [3:0] CCS_IDX_FRC_DIV = 4'h3;
  // Oscillator control field positions
  localparam int CCS_POS_CUR = 12;
  localparam int CCS_POS_NEW = 8;
  localparam int CCS_POS_SEL_LOCK = 7;
  localparam int CCS_POS_PLL_LOCK = 5;
  localparam int CCS_POS_CLK_FAIL = 3;
  localparam int CCS_POS_SEC_EN = 1;
  localparam int CCS_POS_SW_REQ = 0;
  // Interrupt status and mask bit positions
  localparam int CCS_IRQ_DONE = 0;
  localparam int CCS_IRQ_ABORT = 1;
  localparam int CCS_IRQ_FAIL = 2;
  // Source codes
  localparam logic [2:0] CCS_SRC_FRC = 3'h0;
  localparam logic [2:0] CCS_SRC_FRC_PLL = 3'h1;
  localparam logic [2:0] CCS_SRC_PRI = 3'h2;
  localparam logic [2:0] CCS_SRC_PRI_PLL = 3'h3;
  localparam logic [2:0] CCS_SRC_SEC = 3'h4;
  localparam logic [2:0] CCS_SRC_LOW_POWER_RC_OSC = 3'h5;
  localparam logic [2:0] CCS_SRC_LPFRC_DIV = 3'h6;
  localparam logic [2:0] CCS_SRC_FRC_DIV = 3'h7;
  // Primary mode codes
  localparam logic [1:0] CCS_PRI_EXT = 2'h0;
  localparam logic [1:0] CCS_PRI_XT = 2'h1;
  localparam logic [1:0] CCS_PRI_HS = 2'h2;
  // Reset values; source and field values hold only until the configuration fields are caught, divider and mask until written, status until an event
  localparam logic [2:0] CCS_RST_SOURCE = 3'h7;
  localparam logic [1:0] CCS_RST_PRI_MODE = 2'h3;
  localparam logic [1:0] CCS_RST_EXT_RANGE = 2'h3;
  localparam logic [1:0] CCS_RST_SW_MODE = 2'h3;
  localparam logic [2:0] CCS_RST_FRC_DIV = 3'h0;
  localparam logic [2:0] CCS_RST_IRQ = 3'h0;
  // New-clock cycles waited before the switch
  localparam logic [3:0] CCS_SWITCH_WAIT = 4'hA;
  localparam int CCS_SYNC_W = 3;
  typedef enum logic [1:0] {CCS_IDLE, CCS_WAIT_READY, CCS_WAIT_CLK} ccs_state_type;
endpackage

// ---- src/ccs_clock_select.sv ----
// Clock source selection, switching sequence and oscillator control register
`timescale 1ns/1ns
module ccs_clock_select (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] primary_mode_field,
  input wire logic [2:0] initial_source_field,
  input wire logic [1:0] ext_clock_range_field,
  input wire logic [1:0] switch_mode_field,
  input wire logic secondary_power_select,
  input wire logic output_pin_function_bit,
  input wire logic [7:0] src_ready,
  input wire logic pll_locked,
  input wire logic clock_fail,
  input wire logic new_clk,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic [2:0] sel_source,
  output logic [1:0] primary_mode,
  output logic primary_osc_en,
  output logic secondary_osc_en,
  output logic secondary_low_power,
  output logic fast_rc_en,
  output logic lp_fast_rc_en,
  output logic low_power_rc_osc_en,
  output logic pll_en,
  output logic [2:0] fast_rc_divide,
  output logic [1:0] ext_clock_range,
  output logic fail_safe_active,
  output logic instruction_clock,
  output logic crystal_output_pin_o,
  output logic crystal_output_pin_oe_n,
  output logic irq
);
  // Codes that may run through the multiplier
  function automatic logic uses_pll(input logic [2:0] code);
    uses_pll = (code == ccs_pkg::CCS_SRC_PRI_PLL) || (code == ccs_pkg::CCS_SRC_FRC_PLL);
  endfunction

  // Primary oscillator in either form
  function automatic logic is_primary(input logic [2:0] code);
    is_primary = (code == ccs_pkg::CCS_SRC_PRI) || (code == ccs_pkg::CCS_SRC_PRI_PLL);
  endfunction
  // Full-power fast RC in any form
  function automatic logic is_frc(input logic [2:0] code);
    is_frc = (code == ccs_pkg::CCS_SRC_FRC) || (code == ccs_pkg::CCS_SRC_FRC_PLL) || (code == ccs_pkg::CCS_SRC_FRC_DIV);
  endfunction

  logic [ccs_pkg::CCS_SYNC_W-1:0] sync_q;
  logic pll_lock_s, clk_fail_s, new_clk_s;
  logic [7:0] ready_s;

  // Oscillator status arrives from analog blocks on their own timing
  ccs_sync #(.W(ccs_pkg::CCS_SYNC_W)) u_sync_ctl (
    .clk(clk),
    .rst_n(rst_n),
    .d({pll_locked, clock_fail, new_clk}),
    .q(sync_q)
  );
  ccs_sync #(.W(8)) u_sync_rdy (
    .clk(clk),
    .rst_n(rst_n),
    .d(src_ready),
    .q(ready_s)
  );
  assign pll_lock_s = sync_q[2];
  assign clk_fail_s = sync_q[1];
  assign new_clk_s = sync_q[0];

  ccs_pkg::ccs_state_type state_r, state_nxt;
  logic cfg_done_r, cfg_done_nxt;
  logic [1:0] pri_mode_r, pri_mode_nxt, range_r, range_nxt, sw_mode_r, sw_mode_nxt;
  logic sec_lp_r, sec_lp_nxt, pin_fn_r, pin_fn_nxt;
  logic [2:0] cur_r, cur_nxt, new_r, new_nxt, div_r, div_nxt;
  logic sel_lock_r, sel_lock_nxt, pll_lock_r, pll_lock_nxt, cf_r, cf_nxt;
  logic sec_en_r, sec_en_nxt, req_r, req_nxt;
  logic [2:0] stat_r, stat_nxt, mask_r, mask_nxt;
  logic [3:0] edge_cnt_r, edge_cnt_nxt;
  logic new_clk_d_r, fail_d_r, instr_r;
  logic [15:0] rdata_r, rdata_nxt;
  logic switch_en, locked_out, ctrl_wr, new_edge, fail_evt, sw_fin, sw_abort, busy;
  logic [15:0] osc_ctrl_view;

  assign switch_en = !sw_mode_r[1];
  // Selections freeze once locked while switching is possible
  assign locked_out = sel_lock_r && switch_en;
  assign ctrl_wr = reg_wr && (reg_addr == ccs_pkg::CCS_IDX_OSC_CTRL);
  assign new_edge = new_clk_s && !new_clk_d_r;
  assign fail_safe_active = (sw_mode_r == 2'h0);
  assign fail_evt = clk_fail_s && !fail_d_r && fail_safe_active;
  // A pending switch starts the new source, else its ready could never arrive
  assign busy = (state_r != ccs_pkg::CCS_IDLE);

  always_comb begin
    osc_ctrl_view = 16'h0000;
    osc_ctrl_view[ccs_pkg::CCS_POS_CUR +: 3] = cur_r;
    osc_ctrl_view[ccs_pkg::CCS_POS_NEW +: 3] = new_r;
    osc_ctrl_view[ccs_pkg::CCS_POS_SEL_LOCK] = sel_lock_r;
    osc_ctrl_view[ccs_pkg::CCS_POS_PLL_LOCK] = pll_lock_r;
    osc_ctrl_view[ccs_pkg::CCS_POS_CLK_FAIL] = cf_r;
    osc_ctrl_view[ccs_pkg::CCS_POS_SEC_EN] = sec_en_r;
    osc_ctrl_view[ccs_pkg::CCS_POS_SW_REQ] = req_r;
  end

  // Next state of the configuration, register file and switching sequence
  always_comb begin
    state_nxt = state_r;
    cfg_done_nxt = 1'b1;
    pri_mode_nxt = pri_mode_r;
    range_nxt = range_r;
    sw_mode_nxt = sw_mode_r;
    sec_lp_nxt = sec_lp_r;
    pin_fn_nxt = pin_fn_r;
    cur_nxt = cur_r;
    new_nxt = new_r;
    div_nxt = div_r;
    sel_lock_nxt = sel_lock_r;
    pll_lock_nxt = pll_lock_s && uses_pll(cur_r);
    cf_nxt = cf_r;
    sec_en_nxt = sec_en_r;
    req_nxt = req_r;
    mask_nxt = mask_r;
    edge_cnt_nxt = edge_cnt_r;
    sw_fin = 1'b0;
    sw_abort = 1'b0;
    rdata_nxt = 16'h0000;
    if (!cfg_done_r) begin
      pri_mode_nxt = primary_mode_field;
      range_nxt = ext_clock_range_field;
      sw_mode_nxt = switch_mode_field;
      sec_lp_nxt = secondary_power_select;
      pin_fn_nxt = output_pin_function_bit;
      cur_nxt = initial_source_field;
      new_nxt = initial_source_field;
    end
    // Software writes; a lock blocks the selection fields only
    if (ctrl_wr && cfg_done_r) begin
      if (!locked_out && switch_en) begin
        new_nxt = reg_wdata[ccs_pkg::CCS_POS_NEW +: 3];
        if (state_r == ccs_pkg::CCS_IDLE) begin
          req_nxt = reg_wdata[ccs_pkg::CCS_POS_SW_REQ];
        end
      end
      sec_en_nxt = reg_wdata[ccs_pkg::CCS_POS_SEC_EN];
      if (reg_wdata[ccs_pkg::CCS_POS_SEL_LOCK]) begin
        sel_lock_nxt = 1'b1;
      end
      if (!reg_wdata[ccs_pkg::CCS_POS_CLK_FAIL]) begin
        cf_nxt = 1'b0;
      end
    end
    if (reg_wr && (reg_addr == ccs_pkg::CCS_IDX_IRQ_MASK)) begin
      mask_nxt = reg_wdata[2:0];
    end
    if (reg_wr && (reg_addr == ccs_pkg::CCS_IDX_FRC_DIV)) begin
      div_nxt = reg_wdata[2:0];
    end
    // Switching sequence
    case (state_r)
      ccs_pkg::CCS_IDLE: begin
        if (req_r) begin
          if (new_r == cur_r) begin
            req_nxt = 1'b0;
            sw_abort = 1'b1;
          end else begin
            pll_lock_nxt = 1'b0;
            cf_nxt = 1'b0;
            state_nxt = ccs_pkg::CCS_WAIT_READY;
          end
        end
      end
      ccs_pkg::CCS_WAIT_READY: begin
        pll_lock_nxt = 1'b0;
        edge_cnt_nxt = 4'h0;
        if (ready_s[new_r] && (!uses_pll(new_r) || pll_lock_s)) begin
          state_nxt = ccs_pkg::CCS_WAIT_CLK;
        end
      end
      ccs_pkg::CCS_WAIT_CLK: begin
        pll_lock_nxt = 1'b0;
        if (edge_cnt_r == ccs_pkg::CCS_SWITCH_WAIT) begin
          sw_fin = 1'b1;
          cur_nxt = new_r;
          req_nxt = 1'b0;
          state_nxt = ccs_pkg::CCS_IDLE;
        end else if (new_edge) begin
          edge_cnt_nxt = edge_cnt_r + 4'h1;
        end
      end
      default: begin
        state_nxt = ccs_pkg::CCS_IDLE;
      end
    endcase
    if (!switch_en) begin
      req_nxt = 1'b0;
      state_nxt = ccs_pkg::CCS_IDLE;
    end
    // Hardware set beats any clear in the same cycle
    if (fail_evt) begin
      cf_nxt = 1'b1;
    end
    stat_nxt = stat_r;
    if (reg_rd && (reg_addr == ccs_pkg::CCS_IDX_IRQ_STATUS)) begin
      stat_nxt = 3'h0;
    end
    stat_nxt = stat_nxt | {fail_evt, sw_abort, sw_fin};
    // Read mux, unmapped indices read zero
    if (reg_rd) begin
      case (reg_addr)
        ccs_pkg::CCS_IDX_OSC_CTRL: rdata_nxt = osc_ctrl_view;
        ccs_pkg::CCS_IDX_IRQ_STATUS: rdata_nxt = {13'h0000, stat_r};
        ccs_pkg::CCS_IDX_IRQ_MASK: rdata_nxt = {13'h0000, mask_r};
        ccs_pkg::CCS_IDX_FRC_DIV: rdata_nxt = {13'h0000, div_r};
        default: rdata_nxt = 16'h0000;
      endcase
    end
  end

  // State registers; unprogrammed values hold until configuration is caught
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ccs_pkg::CCS_IDLE;
      cfg_done_r <= 1'b0;
      pri_mode_r <= ccs_pkg::CCS_RST_PRI_MODE;
      range_r <= ccs_pkg::CCS_RST_EXT_RANGE;
      sw_mode_r <= ccs_pkg::CCS_RST_SW_MODE;
      sec_lp_r <= 1'b1;
      pin_fn_r <= 1'b1;
      cur_r <= ccs_pkg::CCS_RST_SOURCE;
      new_r <= ccs_pkg::CCS_RST_SOURCE;
      div_r <= ccs_pkg::CCS_RST_FRC_DIV;
      sel_lock_r <= 1'b0;
      pll_lock_r <= 1'b0;
      cf_r <= 1'b0;
      sec_en_r <= 1'b0;
      req_r <= 1'b0;
      stat_r <= ccs_pkg::CCS_RST_IRQ;
      mask_r <= ccs_pkg::CCS_RST_IRQ;
      edge_cnt_r <= 4'h0;
      new_clk_d_r <= 1'b0;
      fail_d_r <= 1'b0;
      instr_r <= 1'b0;
      rdata_r <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      cfg_done_r <= cfg_done_nxt;
      pri_mode_r <= pri_mode_nxt;
      range_r <= range_nxt;
      sw_mode_r <= sw_mode_nxt;
      sec_lp_r <= sec_lp_nxt;
      pin_fn_r <= pin_fn_nxt;
      cur_r <= cur_nxt;
      new_r <= new_nxt;
      div_r <= div_nxt;
      sel_lock_r <= sel_lock_nxt;
      pll_lock_r <= pll_lock_nxt;
      cf_r <= cf_nxt;
      sec_en_r <= sec_en_nxt;
      req_r <= req_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      edge_cnt_r <= edge_cnt_nxt;
      new_clk_d_r <= new_clk_s;
      fail_d_r <= clk_fail_s;
      instr_r <= !instr_r;
      rdata_r <= rdata_nxt;
    end
  end

  // source decode, primary kind passed with the code
  assign sel_source = cur_r;
  assign primary_mode = pri_mode_r;
  assign primary_osc_en = is_primary(cur_r) || (busy && is_primary(new_r));
  assign secondary_osc_en = (cur_r == ccs_pkg::CCS_SRC_SEC) || (busy && new_r == ccs_pkg::CCS_SRC_SEC) || sec_en_r;
  assign secondary_low_power = sec_lp_r;
  assign fast_rc_en = is_frc(cur_r) || (busy && is_frc(new_r));
  assign lp_fast_rc_en = (cur_r == ccs_pkg::CCS_SRC_LPFRC_DIV) || (busy && new_r == ccs_pkg::CCS_SRC_LPFRC_DIV);
  assign low_power_rc_osc_en = (cur_r == ccs_pkg::CCS_SRC_LOW_POWER_RC_OSC) || (busy && new_r == ccs_pkg::CCS_SRC_LOW_POWER_RC_OSC);
  assign pll_en = uses_pll(cur_r) || (busy && uses_pll(new_r));
  assign fast_rc_divide = div_r;
  assign ext_clock_range = range_r;
  assign instruction_clock = instr_r;
  // pin carries instruction clock unless crystal or pin kept as I/O
  assign crystal_output_pin_o = instr_r;
  assign crystal_output_pin_oe_n = pin_fn_r || (is_primary(cur_r) && (pri_mode_r != ccs_pkg::CCS_PRI_EXT));
  assign irq = |(stat_r & mask_r);
  assign reg_rdata = rdata_r;

  req_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    !switch_en |=> !req_r) else $error("switch request set while switching disabled");
  abort_same_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_r == ccs_pkg::CCS_IDLE && req_r && new_r == cur_r && !ctrl_wr) |=> !req_r && stat_r[ccs_pkg::CCS_IRQ_ABORT])
    else $error("redundant switch not aborted");
  start_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_r == ccs_pkg::CCS_IDLE && req_r && new_r != cur_r && switch_en) |=> !pll_lock_r
    && state_r == ccs_pkg::CCS_WAIT_READY) else $error("switch start did not clear lock");
  wait_ten_a: assert property (@(posedge clk) disable iff (!rst_n)
    sw_fin |-> edge_cnt_r == 4'hA && $past(state_r) == ccs_pkg::CCS_WAIT_CLK)
    else $error("switch taken before ten new clocks");
  fin_copy_a: assert property (@(posedge clk) disable iff (!rst_n)
    sw_fin |=> cur_r == $past(new_r) && !req_r) else $error("current source not updated on switch");
  cur_stable_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg_done_r && !sw_fin) |=> $stable(cur_r)) else $error("current source changed without switch");
  lock_sticky_a: assert property (@(posedge clk) disable iff (!rst_n)
    sel_lock_r |=> sel_lock_r) else $error("selection lock cleared");
  instr_half_a: assert property (@(posedge clk) disable iff (!rst_n)
    instr_r |=> !instr_r ##1 instr_r) else $error("instruction clock not half rate");
  fsm_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    fail_evt |=> cf_r && $past(sw_mode_r) == 2'h0) else $error("fail flag outside fail-safe mode");
  switch_done_c: cover property (@(posedge clk) disable iff (!rst_n) sw_fin);
  switch_abort_c: cover property (@(posedge clk) disable iff (!rst_n) sw_abort);
  clock_fail_c: cover property (@(posedge clk) disable iff (!rst_n) fail_evt ##1 irq);
endmodule // ccs_clock_select

// ---- src/ccs_sync.sv ----
// Two flip-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ns
module ccs_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q_r <= '0;
    end else begin
      meta_r <= d;
      q_r <= meta_r;
    end
  end

  assign q = q_r;
endmodule // ccs_sync

// ---- test/ccs_osc_model.sv ----
// Oscillator sources, multiplier lock and clock monitor facing the selector
`timescale 1ns/1ns
module ccs_osc_model #(
  parameter int START = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic fast_rc_en,
  input wire logic lp_fast_rc_en,
  input wire logic low_power_rc_osc_en,
  input wire logic secondary_osc_en,
  input wire logic primary_osc_en,
  input wire logic pll_en,
  input wire logic fail_cmd,
  output logic [7:0] src_ready,
  output logic pll_locked,
  output logic clock_fail,
  output logic new_clk
);
  logic [8:0] on_w;
  int cnt [9];
  // Running flag per code; codes sharing one oscillator share its enable, bit 8 is the multiplier
  assign on_w = {pll_en, fast_rc_en, lp_fast_rc_en, low_power_rc_osc_en, secondary_osc_en, primary_osc_en, primary_osc_en,
    fast_rc_en, fast_rc_en};
  // multiplier lock wait
  // Start-up counts; a stopped oscillator or multiplier drops ready at once, never lingers
  always_ff @(posedge clk or negedge rst_n) begin
    for (int i = 0; i < 9; i++) begin
      if (!rst_n || !on_w[i]) cnt[i] <= 0;
      else if (cnt[i] < START) cnt[i] <= cnt[i] + 1;
    end
  end
  // Ready and lock levels from the counts
  always_comb begin
    for (int i = 0; i < 8; i++) src_ready[i] = (cnt[i] == START);
    pll_locked = (cnt[8] == START);
  end
  assign clock_fail = fail_cmd;
  // candidate source clock
  // Free-running at 62 ns, unrelated in phase to clk
  initial new_clk = 1'b0;
  always #31 new_clk = ~new_clk;
endmodule // ccs_osc_model

// ---- test/clock_source_select_tb.sv ----
// Random and directed checks of the clock source selector
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module clock_source_select_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] primary_mode_field = 2'h3, ext_clock_range_field = 2'h3, switch_mode_field = 2'h3;
  logic [2:0] initial_source_field = 3'h7;
  logic secondary_power_select = 1'h1, output_pin_function_bit = 1'h1, fail_cmd = 1'h0;
  logic reg_wr = 1'h0, reg_rd = 1'h0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, d;
  logic [7:0] src_ready;
  logic [2:0] sel_source, fast_rc_divide, cc, t;
  logic [1:0] primary_mode, ext_clock_range;
  logic pll_locked, clock_fail, new_clk, primary_osc_en, secondary_osc_en, secondary_low_power, fast_rc_en;
  logic lp_fast_rc_en, low_power_rc_osc_en, pll_en, fail_safe_active, instruction_clock, crystal_output_pin_o;
  logic crystal_output_pin_oe_n, irq, a, drv;
  logic [31:0] r;
  logic [2:0] tl [4] = '{3'h3, 3'h4, 3'h1, 3'h0};
  int err_count = 0;
  int checks_done = 0;
  logic [31:0] seed = 32'h0000BD5A; // 48474

  ccs_clock_select uut (.*);
  ccs_osc_model osc (.*);

  // 100 MHz system clock
  always #5 clk = ~clk;

  // Repeatable xorshift source
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Control word expected once a source is settled, secondary enable kept on
  function automatic logic [15:0] exp_ctrl(input logic [2:0] s);
    return {1'b0, s, 1'b0, s, 2'h0, s == 3'h1 || s == 3'h3, 5'h02};
  endfunction

  // Enable output that must be up for a source code
  function automatic logic src_on(input logic [2:0] s);
    case (s)
      3'h2, 3'h3: return primary_osc_en;
      3'h4: return secondary_osc_en;
      3'h5: return low_power_rc_osc_en;
      3'h6: return lp_fast_rc_en;
      default: return fast_rc_en;
    endcase
  endfunction

  task automatic wr16(input logic [3:0] ad, input logic [15:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data is taken in the one cycle after the strobe
  task automatic rd16(input logic [3:0] ad, output logic [15:0] v);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  // Configuration fields are caught at the first edge after release
  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic do_switch(input logic [2:0] s, input logic masked);
    int n;
    logic [15:0] v;
    n = 0;
    wr16(4'h0, {5'h00, s, 8'h02});
    wr16(4'h0, {5'h00, s, 8'h03});
    while (sel_source !== s && n < 3000) begin
      @(posedge clk);
      #1 n++;
    end
    `CHK("switch time", 1'b1, n >= 54)
    rd16(4'h0, v);
    `CHK("ctrl after switch", exp_ctrl(s), v)
    `CHK("irq level", masked, irq)
    rd16(4'h1, v);
    `CHK("status done", 16'h0001, v)
    @(posedge clk);
    #1 `CHK("irq cleared", 1'b0, irq)
  endtask

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Cuts a hang short; the whole run needs well under 50 us
  initial begin
    #500000;
    err_count++;
    wrap_up();
  end

  initial begin
    do_reset();
    `CHK("reset source", 3'h7, sel_source)
    rd16(4'h0, d);
    `CHK("reset ctrl", 16'h7700, d)
    `CHK("fail-safe off", 1'b0, fail_safe_active)
    wr16(4'h0, 16'h0101);
    rd16(4'h0, d);
    `CHK("request ignored", 16'h7700, d)
    repeat (20) @(posedge clk);
    #1 `CHK("no switch", 3'h7, sel_source)
    rd16(4'h9, d);
    `CHK("unmapped read", 16'h0000, d)
    r = xs();
    wr16(4'h3, {13'h0000, r[2:0]});
    rd16(4'h3, d);
    `CHK("divider read", {13'h0000, r[2:0]}, d)
    `CHK("divider out", r[2:0], fast_rc_divide)
    $display("Test defaults done");
    // Every source code with random remaining configuration
    for (int c = 0; c < 8; c++) begin
      cc = c[2:0];
      r = xs();
      initial_source_field <= cc;
      primary_mode_field <= r[1:0];
      ext_clock_range_field <= r[3:2];
      switch_mode_field <= r[5:4];
      secondary_power_select <= r[6];
      output_pin_function_bit <= r[7];
      do_reset();
      repeat (20) @(posedge clk);
      #1 `CHK("source", cc, sel_source)
      `CHK("primary mode", r[1:0], primary_mode)
      `CHK("ext range", r[3:2], ext_clock_range)
      `CHK("fail-safe", r[5:4] == 2'h0, fail_safe_active)
      `CHK("secondary power", r[6], secondary_low_power)
      `CHK("multiplier", cc == 3'h1 || cc == 3'h3, pll_en)
      `CHK("source enable", 1'b1, src_on(cc))
      drv = !r[7] && !((cc == 3'h2 || cc == 3'h3) && (r[1:0] != 2'h0));
      `CHK("pin enable", !drv, crystal_output_pin_oe_n)
      if (drv) `CHK("pin value", instruction_clock, crystal_output_pin_o)
      a = instruction_clock;
      @(posedge clk);
      #1 `CHK("cycle clock", !a, instruction_clock)
    end
    $display("Test configuration done");
    initial_source_field <= 3'h7;
    primary_mode_field <= 2'h2;
    switch_mode_field <= 2'h0;
    output_pin_function_bit <= 1'b1;
    do_reset();
    wr16(4'h2, 16'h0007);
    for (int k = 0; k < 5; k++) begin
      r = xs();
      t = (k < 4) ? tl[k] : r[2:0];
      if (t === sel_source) t = t ^ 3'h1;
      if (k == 3) wr16(4'h2, 16'h0000);
      do_switch(t, k < 3);
    end
    wr16(4'h0, {5'h00, sel_source, 8'h03});
    repeat (4) @(posedge clk);
    rd16(4'h1, d);
    `CHK("abort status", 16'h0002, d)
    rd16(4'h0, d);
    `CHK("abort request", 1'b0, d[0])
    $display("Test switching done");
    cc = sel_source;
    fail_cmd <= 1'b1;
    repeat (6) @(posedge clk);
    rd16(4'h0, d);
    `CHK("fail flag", 1'b1, d[3])
    rd16(4'h1, d);
    `CHK("fail status", 16'h0004, d)
    fail_cmd <= 1'b0;
    wr16(4'h0, {1'b0, ~cc, 1'b0, cc, 8'h02});
    rd16(4'h0, d);
    `CHK("fail cleared", exp_ctrl(cc), d)
    wr16(4'h0, {5'h00, cc, 8'h82});
    wr16(4'h0, {5'h00, cc, 8'h02});
    rd16(4'h0, d);
    `CHK("lock set only", 1'b1, d[7])
    wr16(4'h0, {5'h00, cc ^ 3'h1, 8'h83});
    repeat (150) @(posedge clk);
    #1 `CHK("locked source", cc, sel_source)
    $display("Test flags done");
    wrap_up();
  end
endmodule // clock_source_select_tb
